// File: test/sttr_host_model.sv
// host side model: register strobes and bus transaction starts
// assumes the bank samples every request on the rising edge of mclk
module sttr_host_model (
  input wire logic mclk, // core clock
  input wire logic [7:0] rdData, // read data from the bank
  input wire logic rdValid, // read answer strobe
  output sttr_pkg::sttr_req_t req, // register request
  output logic busStart // transaction start pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    req = '0;
    busStart = 1'b0;
  end
  // idle fields show inverted junk so a stale value never helps the bank
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic st);
    @(posedge mclk) #1;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    busStart = st;
    @(posedge mclk) #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    busStart = 1'b0;
  endtask
  // read answer lands on the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk) #1;
    d = rdData;
    v = rdValid;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
  endtask
  // two reads back to back, the second strobe raised as the first answer lands
  task automatic rdPair(input logic [7:0] a, input logic [7:0] b, output logic [7:0] d1, output logic [7:0] d2);
    @(posedge mclk) #1;
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk) #1;
    d1 = rdData;
    req = '{wr: 1'b0, rd: 1'b1, addr: b, wdata: 8'h00};
    @(posedge mclk) #1;
    d2 = rdData;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~b, wdata: 8'hFF};
  endtask
  task automatic start();
    @(posedge mclk) #1;
    busStart = 1'b1;
    @(posedge mclk) #1;
    busStart = 1'b0;
  endtask
  task automatic setAddr(input logic [6:0] a);
    wr(8'h0C, {a, 1'b1}, 1'b0);
    start();
  endtask
endmodule // sttr_host_model

// File: test/test_sttr_regs.sv
// self-checking bench for the trim and id bank
// assumes the host model drives all register traffic
module test_sttr_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, arst_n = 0, otpValid = 0, tempValid = 0, gainAxisSel = 0;
  logic [6:0] otpAddr = 7'h12;
  logic [15:0] tempResult = 16'hBEEF;
  logic [1:0] anglePair = 2'h1;
  logic [1:0] rangeVariant = 2'h2;
  logic [7:0] lsbRes = 8'h03;
  sttr_pkg::sttr_axes_t axes = '{x: 16'h0064, y: 16'hFFD8, z: 16'h0007};
  sttr_pkg::sttr_req_t req;
  logic busStart, rdValid;
  logic [7:0] rdData;
  logic [7:0] pairLo, pairHi;
  logic [6:0] targetAddr;
  logic [17:0] firstCorr, secondCorr;
  int err_total = 0, checks_done = 0;
  sttr_regs #(.MAKER_CODE(16'h3C5A)) sttr_regs_inst (.mclk(mclk), .arst_n(arst_n), .req(req),
    .busStart(busStart), .otpValid(otpValid), .otpAddr(otpAddr), .rangeVariant(rangeVariant),
    .tempValid(tempValid), .tempResult(tempResult), .axes(axes), .anglePair(anglePair),
    .gainAxisSel(gainAxisSel), .lsbRes(lsbRes), .rdData(rdData), .rdValid(rdValid),
    .targetAddr(targetAddr), .firstCorr(firstCorr), .secondCorr(secondCorr));
  sttr_host_model host_inst (.mclk(mclk), .rdData(rdData), .rdValid(rdValid), .req(req),
    .busStart(busStart));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host_inst.rd(a, d, v);
    chk({v, 9'h000, d}, {1'b1, 9'h000, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // datapath: set selects, let the registered outputs settle, compare
  task automatic dp(input logic [1:0] p, input logic s, input logic [17:0] f, input logic [17:0] t);
    anglePair = p;
    gainAxisSel = s;
    cyc(3);
    chk(firstCorr, f);
    chk(secondCorr, t);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog, tests take well under a thousand cycles
  initial begin
    #40000;
    err_total++;
    end_of_test();
  end
  initial begin
    cyc(12);
    arst_n = 1;
    cyc(3);
    chk(targetAddr, 18'h35);
    rc(8'h09, 8'h00);
    rc(8'h0A, 8'h00);
    rc(8'h0B, 8'h00);
    rc(8'h0C, 8'h6A);
    rc(8'h0D, 8'h06);
    rc(8'h0E, 8'h5A);
    rc(8'h0F, 8'h3C);
    rc(8'h20, 8'h00);
    cyc(1);
    chk(rdValid, 18'h0);
    host_inst.rdPair(8'h0E, 8'h0F, pairLo, pairHi);
    chk(pairLo, 18'h5A);
    chk(pairHi, 18'h3C);
    $display("reset values done");
    host_inst.wr(8'h0E, 8'hFF, 1'b0);
    host_inst.wr(8'h0D, 8'hFF, 1'b0);
    rc(8'h0E, 8'h5A);
    rc(8'h0D, 8'h06);
    @(posedge mclk) #1 tempValid = 1;
    @(posedge mclk) #1 tempValid = 0;
    host_inst.wr(8'h10, 8'h55, 1'b0);
    rc(8'h10, 8'hBE);
    rc(8'h11, 8'hEF);
    $display("read only done");
    host_inst.wr(8'h0A, 8'hFE, 1'b0);
    host_inst.wr(8'h0B, 8'h05, 1'b0);
    dp(2'h1, 1'b0, 18'sd94, -18'sd25);
    dp(2'h3, 1'b0, 18'sd94, 18'sd22);
    host_inst.wr(8'h09, 8'h80, 1'b0);
    rc(8'h09, 8'h80);
    dp(2'h1, 1'b0, 18'sd44, -18'sd25);
    dp(2'h1, 1'b1, 18'sd94, -18'sd5);
    dp(2'h2, 1'b0, -18'sd26, 18'sd22);
    dp(2'h3, 1'b0, 18'sd44, 18'sd22);
    dp(2'h0, 1'b0, 18'sd44, -18'sd25);
    host_inst.wr(8'h0A, 8'h00, 1'b0);
    dp(2'h1, 1'b0, 18'sd50, -18'sd25);
    dp(2'h2, 1'b1, -18'sd40, 18'sd18);
    $display("datapath done");
    host_inst.wr(8'h0C, 8'h40, 1'b0);
    host_inst.start();
    cyc(2);
    chk(targetAddr, 18'h35);
    rc(8'h0C, 8'h40);
    host_inst.wr(8'h0C, 8'h41, 1'b1);
    cyc(3);
    chk(targetAddr, 18'h35);
    host_inst.start();
    cyc(2);
    chk(targetAddr, 18'h20);
    @(posedge mclk) #1 otpValid = 1;
    @(posedge mclk) #1 otpValid = 0;
    cyc(1);
    chk(targetAddr, 18'h12);
    rc(8'h0C, 8'h24);
    $display("address done");
    // a second reset must drop the factory address from the otp load
    arst_n = 0;
    rangeVariant = 2'h0;
    cyc(2);
    arst_n = 1;
    cyc(3);
    chk(targetAddr, 18'h35);
    rc(8'h0C, 8'h6A);
    rc(8'h0D, {6'h01, 2'h0});
    host_inst.setAddr(7'h2B);
    cyc(2);
    chk(targetAddr, 18'h2B);
    $display("power cycle done");
    end_of_test();
  end
endmodule // test_sttr_regs

// File: verilog/sttr_map.svh
// holds register offsets, reset values and select encodings of the trim and id bank
// assumes byte wide offsets as seen by the sensor's own bus target engine
`ifndef STTR_MAP_SVH
`define STTR_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define STTR_OFF_GAIN 8'h09
`define STTR_OFF_OFFSET1 8'h0A
`define STTR_OFF_OFFSET2 8'h0B
`define STTR_OFF_ADDR 8'h0C
`define STTR_OFF_VERSION 8'h0D
`define STTR_OFF_MAKER_LO 8'h0E
`define STTR_OFF_MAKER_HI 8'h0F
`define STTR_OFF_TEMP_HI 8'h10
`define STTR_OFF_TEMP_LO 8'h11

// ------------------------------------------------------------
// reset values and fixed fields
// ------------------------------------------------------------
`define STTR_RST_TRIM 8'h00
`define STTR_RST_ADDR 8'h6A
`define STTR_RST_TARGET 7'h35
`define STTR_RST_TEMP 16'h0000
`define STTR_VER_UPPER 6'h01
`define STTR_ADDR_APPLY_BIT 0
`define STTR_GAIN_UNITY 10'h100
`define STTR_GAIN_SHIFT 8

// ------------------------------------------------------------
// axis pair and gain axis encodings
// ------------------------------------------------------------
`define STTR_PAIR_NONE 2'h0
`define STTR_PAIR_XY 2'h1
`define STTR_PAIR_YZ 2'h2
`define STTR_PAIR_XZ 2'h3
`define STTR_GAIN_FIRST 1'h0
`define STTR_GAIN_SECOND 1'h1
`endif

// File: verilog/sttr_pkg.sv
// holds the types shared by the trim and id bank
// assumes sttr_map.svh supplies all numbers
package sttr_pkg;
  // register access from the bus target engine, same clock
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sttr_req_t;

  // raw hall axis samples, two's complement
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } sttr_axes_t;

  // whole state of the bank
  typedef struct packed {
    logic started;
    logic [7:0] gain;
    logic [7:0] off1;
    logic [7:0] off2;
    logic [7:0] addrField;
    logic [6:0] target;
    logic pendValid;
    logic [1:0] variant;
    logic [15:0] tempRes;
    logic [7:0] rdData;
    logic rdValid;
    logic [17:0] first;
    logic [17:0] second;
  } sttr_state_t;
endpackage

// File: verilog/sttr_regs.sv
// holds the trim, target address, version, maker code and temperature registers
// assumes the bus target engine, otp loader and conversion core share mclk
// What this block does
// - gain register is an unsigned fraction, value over 256, scaling one axis.
// - a gain register of zero applies unity gain, not zero.
// - gain axis chosen by gain axis select together with axis pair select.
// - first offset is signed eight bit, added to first axis of pair.
// - second offset is signed eight bit, added to second axis of pair.
// - applied offset equals signed register times resolution per lsb.
// - otp factory address loads into address field at power up; reset 35h.
// - new address used at the next transaction start after a write with apply bit one, taking the field as it stands then.
// - read only two bit version field shows the range variant.
// - fixed sixteen bit maker code, low byte at lower offset.
// - temperature result readable as high byte then low byte.
`include "sttr_map.svh"

module sttr_regs #(
  parameter logic [15:0] MAKER_CODE = 16'hA5C3 // arbitrary neutral value
) (
  input wire logic mclk, // core clock, 50 MHz
  input wire logic arst_n, // async reset, active low
  input wire sttr_pkg::sttr_req_t req, // register access, one cycle strobes
  input wire logic busStart, // pulse at each bus transaction start
  input wire logic otpValid, // pulse when factory address is loaded
  input wire logic [6:0] otpAddr, // factory target address
  input wire logic [1:0] rangeVariant, // range option strap, caught after reset
  input wire logic tempValid, // pulse with a new temperature result
  input wire logic [15:0] tempResult, // temperature conversion result
  input wire sttr_pkg::sttr_axes_t axes, // raw hall samples
  input wire logic [1:0] anglePair, // angle axis pair select
  input wire logic gainAxisSel, // gain applies to first or second axis
  input wire logic [7:0] lsbRes, // resolution per lsb of active range
  output logic [7:0] rdData, // read data, valid with rdValid
  output logic rdValid, // one cycle after a read strobe
  output logic [6:0] targetAddr, // address matched by the bus engine
  output logic [17:0] firstCorr, // first axis after gain and offset
  output logic [17:0] secondCorr // second axis after gain and offset
);
  sttr_pkg::sttr_state_t s;
  sttr_pkg::sttr_state_t n;
  logic [9:0] gainEff;

  // ------------------------------------------------------------
  // gain interpretation
  // ------------------------------------------------------------
  // zero means unity
  assign gainEff = (s.gain == `STTR_RST_TRIM) ? `STTR_GAIN_UNITY : {2'h0, s.gain};

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // one process computes all next values so ordering of set and clear is explicit
  always_comb begin
    logic [15:0] a1;
    logic [15:0] a2;
    logic [9:0] g1;
    logic [9:0] g2;
    logic signed [25:0] p1;
    logic signed [25:0] p2;
    logic signed [25:0] o1;
    logic signed [25:0] o2;
    logic signed [25:0] sum1;
    logic signed [25:0] sum2;
    a1 = axes.x;
    a2 = axes.y;
    g1 = `STTR_GAIN_UNITY;
    g2 = `STTR_GAIN_UNITY;
    p1 = '0;
    p2 = '0;
    o1 = '0;
    o2 = '0;
    sum1 = '0;
    sum2 = '0;
    n = s;
    n.rdValid = 1'b0;
    // strap is caught on the first edge after release, never under reset
    if (!s.started) begin
      n.started = 1'b1;
      n.variant = rangeVariant;
    end
    // factory address into field and matcher
    if (otpValid) begin
      n.addrField = {otpAddr, 1'b0};
      n.target = otpAddr;
      n.pendValid = 1'b0;
    end
    // switch only at a transaction start; a factory load in the same cycle wins
    if (busStart && s.pendValid && !otpValid) begin
      n.target = s.addrField[7:1];
      n.pendValid = 1'b0;
    end
    // writes after the start handling so a fresh apply is never lost
    if (req.wr) begin
      case (req.addr)
        `STTR_OFF_GAIN: n.gain = req.wdata;
        `STTR_OFF_OFFSET1: n.off1 = req.wdata;
        `STTR_OFF_OFFSET2: n.off2 = req.wdata;
        `STTR_OFF_ADDR: begin
          n.addrField = req.wdata;
          if (req.wdata[`STTR_ADDR_APPLY_BIT]) begin
            n.pendValid = 1'b1;
          end
        end
        default: ; // read only and unmapped writes are ignored
      endcase
    end
    if (tempValid) begin
      n.tempRes = tempResult;
    end
    // read mux, unmapped offsets answer zero
    if (req.rd) begin
      n.rdValid = 1'b1;
      case (req.addr)
        `STTR_OFF_GAIN: n.rdData = s.gain;
        `STTR_OFF_OFFSET1: n.rdData = s.off1;
        `STTR_OFF_OFFSET2: n.rdData = s.off2;
        `STTR_OFF_ADDR: n.rdData = s.addrField;
        `STTR_OFF_VERSION: n.rdData = {`STTR_VER_UPPER, s.variant};
        `STTR_OFF_MAKER_LO: n.rdData = MAKER_CODE[7:0];
        `STTR_OFF_MAKER_HI: n.rdData = MAKER_CODE[15:8];
        `STTR_OFF_TEMP_HI: n.rdData = s.tempRes[15:8];
        `STTR_OFF_TEMP_LO: n.rdData = s.tempRes[7:0];
        default: n.rdData = 8'h00;
      endcase
    end
    // pick the pair; no pair selected falls back to x and y
    case (anglePair)
      `STTR_PAIR_YZ: begin
        a1 = axes.y;
        a2 = axes.z;
      end
      `STTR_PAIR_XZ: begin
        a1 = axes.x;
        a2 = axes.z;
      end
      default: begin
        a1 = axes.x;
        a2 = axes.y;
      end
    endcase
    // gain lands on one member of the pair
    if (gainAxisSel == `STTR_GAIN_SECOND) begin
      g2 = gainEff;
    end else begin
      g1 = gainEff;
    end
    p1 = $signed(a1) * $signed(g1);
    p2 = $signed(a2) * $signed(g2);
    o1 = $signed(s.off1) * $signed({1'b0, lsbRes});
    o2 = $signed(s.off2) * $signed({1'b0, lsbRes});
    sum1 = (p1 >>> `STTR_GAIN_SHIFT) + o1;
    sum2 = (p2 >>> `STTR_GAIN_SHIFT) + o2;
    n.first = sum1[17:0];
    n.second = sum2[17:0];
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // reset loads only constants; the strap is caught later
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.gain <= `STTR_RST_TRIM;
      s.off1 <= `STTR_RST_TRIM;
      s.off2 <= `STTR_RST_TRIM;
      s.addrField <= `STTR_RST_ADDR;
      s.target <= `STTR_RST_TARGET;
      s.tempRes <= `STTR_RST_TEMP;
    end else begin
      s <= n;
    end
  end

  assign rdData = s.rdData;
  assign rdValid = s.rdValid;
  assign targetAddr = s.target;
  assign firstCorr = s.first;
  assign secondCorr = s.second;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence seqApplyWrite;
    req.wr && req.addr == `STTR_OFF_ADDR && req.wdata[0] && !busStart && !otpValid;
  endsequence
  sequence seqStartPending;
    busStart && s.pendValid && !otpValid;
  endsequence

  a_gain_zero_unity: assert property ((s.gain == 8'h00 && s.off1 == 8'h00 && gainAxisSel == 1'b0
      && anglePair != 2'h2) |=> firstCorr == {{2{$past(axes.x[15])}}, $past(axes.x)})
    else $error("zero gain not unity");
  a_gain_fraction: assert property ((s.gain != 8'h00 && gainAxisSel == 1'b0 && anglePair == 2'h1
      && s.off1 == 8'h00) |=> $signed(firstCorr)
      == 18'(26'($signed($past(axes.x)) * $signed({2'h0, $past(s.gain)})) >>> 8))
    else $error("gain fraction wrong");
  a_gain_axis_pick: assert property ((gainAxisSel == 1'b1 && anglePair == 2'h2 && s.off1 == 8'h00)
      |=> firstCorr == {{2{$past(axes.y[15])}}, $past(axes.y)})
    else $error("gain on wrong axis");
  a_offset_first: assert property ((s.gain == 8'h00 && anglePair == 2'h3)
      |=> $signed(firstCorr) == 18'($signed($past(axes.x)) + $signed($past(s.off1)) * $signed({1'b0, $past(lsbRes)})))
    else $error("first offset wrong");
  a_offset_second: assert property ((s.gain == 8'h00 && anglePair == 2'h3)
      |=> $signed(secondCorr) == 18'($signed($past(axes.z)) + $signed($past(s.off2)) * $signed({1'b0, $past(lsbRes)})))
    else $error("second offset wrong");
  a_otp_load: assert property (otpValid && !req.wr |=> targetAddr == $past(otpAddr)
      && s.addrField == {$past(otpAddr), 1'b0})
    else $error("otp address not loaded");
  a_apply_wait: assert property (seqApplyWrite |=> s.pendValid && targetAddr == $past(targetAddr))
    else $error("address applied too early");
  a_apply_start: assert property (seqStartPending |=> targetAddr == $past(s.addrField[7:1]))
    else $error("address not applied at start");
  a_no_apply: assert property ((!s.pendValid && !otpValid) ##1 (busStart && !s.pendValid && !otpValid)
      |=> $stable(targetAddr))
    else $error("address changed without apply");
  a_version_read: assert property (req.rd && req.addr == 8'h0D |=> rdValid && rdData == {6'h01, $past(s.variant)})
    else $error("version read wrong");
  a_maker_read: assert property (req.rd && req.addr == 8'h0E ##1 req.rd && req.addr == 8'h0F
      |=> rdData == MAKER_CODE[15:8] && $past(rdData) == MAKER_CODE[7:0])
    else $error("maker code read wrong");
  a_temp_read: assert property (req.rd && req.addr == 8'h10 |=> rdData == $past(s.tempRes[15:8]))
    else $error("temperature high byte wrong");
endmodule // sttr_regs
